// ### core/lss_top.sv
// status indicator select: AXI4-Lite registers, combine, stretch
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module lss_top
  import lss_pkg::*;
#(
  parameter int STRETCH_CYCLES = LSS_STRETCH_CYCLES
) (
  input wire logic CLK,
  input wire logic RESET,
  // register bus
  input wire logic [LSS_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [LSS_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // network event sources
  input wire logic TX_ACTIVE,
  input wire logic RX_ACTIVE,
  input wire logic RX_ADDR_MATCH,
  input wire logic COLLISION,
  input wire logic JABBER,
  input wire logic RX_POLARITY_OK,
  input wire logic LINK_PASS,
  input wire logic WAKE_FRAME_RX,
  input wire lss_port_t ACTIVE_PORT,
  // soft events that must leave the duplex bits alone
  input wire logic SOFT_RESET_READ,
  input wire logic STOP_CMD,
  // indicator
  output logic THIRD_INDICATOR_PIN
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  lss_sel_t sel;
  lss_misc_t misc;
  lss_func_t func;
  lss_func_t en;
  logic comb;
  logic busy;
  logic fdx_fn;
  logic aw_got;
  logic w_got;
  logic [LSS_ADDR_W-1:0] waddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic do_write;
  logic [15:0] next_sel;
  logic [15:0] next_misc;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic rd_is_sel;

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  // address and data are taken in either order; the register
  // update waits until both are held
  assign do_write = aw_got && w_got;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= LSS_RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      waddr <= '0;
      wdata <= '0;
      wstrb <= '0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        S_AXI_AWREADY <= 1'b0;
        aw_got <= 1'b1;
        waddr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        S_AXI_WREADY <= 1'b0;
        w_got <= 1'b1;
        wdata <= S_AXI_WDATA;
        wstrb <= S_AXI_WSTRB;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        if (waddr == LSS_OFS_SEL || waddr == LSS_OFS_MISC) begin
          S_AXI_BRESP <= LSS_RESP_OKAY;
        end else begin
          S_AXI_BRESP <= LSS_RESP_SLVERR;
        end
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // selection register
  // ----------------------------------------------------------------
  // reserved and read-only bits are masked off on write
  assign next_sel = lss_merge(sel, wdata[15:0], wstrb,
                              LSS_SEL_WMASK);

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      sel <= LSS_SEL_RESET;
    end else if (do_write && waddr == LSS_OFS_SEL) begin
      sel <= next_sel;
    end
  end

  // ----------------------------------------------------------------
  // duplex configuration register
  // ----------------------------------------------------------------
  // soft reset and stop do not reach this register at all
  assign next_misc = lss_merge(misc, wdata[15:0], wstrb,
                               LSS_MISC_WMASK);

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      misc <= LSS_MISC_RESET;
    end else if (do_write && waddr == LSS_OFS_MISC) begin
      misc <= next_misc;
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = '0;
    next_rresp = LSS_RESP_OKAY;
    if (S_AXI_ARADDR == LSS_OFS_SEL) begin
      next_rdata[15:0] = sel;
      next_rdata[15] = comb;
    end else if (S_AXI_ARADDR == LSS_OFS_MISC) begin
      next_rdata[15:0] = misc;
    end else begin
      next_rresp = LSS_RESP_SLVERR;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= LSS_RESP_OKAY;
      rd_is_sel <= 1'b0;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= next_rdata;
      S_AXI_RRESP <= next_rresp;
      rd_is_sel <= (S_AXI_ARADDR == LSS_OFS_SEL);
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // function states
  // ----------------------------------------------------------------
  // an unknown port code never claims full duplex
  always_comb begin
    unique case (ACTIVE_PORT)
      LSS_PORT_TP: fdx_fn = LINK_PASS &&
                            misc.full_duplex_enable;
      LSS_PORT_AUI: fdx_fn = misc.full_duplex_enable &&
                             misc.attach_port_fdx_enable;
      LSS_PORT_SERIAL: fdx_fn = misc.full_duplex_enable;
      default: fdx_fn = 1'b0;
    endcase
  end

  always_comb begin
    func.wake = WAKE_FRAME_RX;
    func.fdx_link = fdx_fn;
    func.tx = TX_ACTIVE;
    func.polarity = RX_POLARITY_OK;
    func.rx = RX_ACTIVE &&
              (!sel.rx_match_only || RX_ADDR_MATCH);
    func.jabber = JABBER;
    func.collision = COLLISION;
  end

  always_comb begin
    en.wake = sel.wake_frame_ind_en;
    en.fdx_link = sel.fdx_link_ind_en;
    en.tx = sel.tx_activity_ind_en;
    en.polarity = sel.rx_polarity_ind_en;
    en.rx = sel.rx_activity_ind_en;
    en.jabber = sel.jabber_ind_en;
    en.collision = sel.collision_ind_en;
  end

  // ----------------------------------------------------------------
  // combine and stretch
  // ----------------------------------------------------------------
  lss_combine u_combine (
    .clk(CLK),
    .reset(RESET),
    .func(func),
    .en(en),
    .comb(comb)
  );

  lss_stretch #(
    .CYCLES(STRETCH_CYCLES)
  ) u_stretch (
    .clk(CLK),
    .reset(RESET),
    .comb(comb),
    .busy(busy)
  );

  // the stretcher keeps counting while disabled, so turning it on
  // mid-pulse may show a short tail
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      THIRD_INDICATOR_PIN <= 1'b0;
    end else if (sel.stretch_enable) begin
      THIRD_INDICATOR_PIN <= comb || busy;
    end else begin
      THIRD_INDICATOR_PIN <= comb;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_reset_value: assert property (
    @(posedge CLK) disable iff (RESET)
    $past(RESET) |-> sel[14:0] == LSS_SEL_RESET[14:0])
    else $error("selection register wrong after reset");

  a_reserved_zero: assert property (
    @(posedge CLK) disable iff (RESET)
    S_AXI_RVALID && rd_is_sel |->
      S_AXI_RDATA[14:10] == 5'h00 && !S_AXI_RDATA[6] &&
      S_AXI_RDATA[31:16] == 16'h0000)
    else $error("reserved selection bits read nonzero");

  a_state_bit_read: assert property (
    @(posedge CLK) disable iff (RESET)
    S_AXI_ARVALID && S_AXI_ARREADY &&
    S_AXI_ARADDR == LSS_OFS_SEL |=>
      S_AXI_RVALID && S_AXI_RDATA[15] == $past(comb))
    else $error("bit 15 does not show combined state");

  a_pin_direct: assert property (
    @(posedge CLK) disable iff (RESET)
    !sel.stretch_enable ##1 !sel.stretch_enable |->
      THIRD_INDICATOR_PIN == $past(comb))
    else $error("indicator not following combined state");

  a_pin_stretched: assert property (
    @(posedge CLK) disable iff (RESET)
    sel.stretch_enable && $rose(comb) && STRETCH_CYCLES >= 8 ##1
    sel.stretch_enable [*5] |-> THIRD_INDICATOR_PIN)
    else $error("indicator dropped inside stretch time");

  a_fdx_link: assert property (
    @(posedge CLK) disable iff (RESET)
    ACTIVE_PORT == LSS_PORT_TP |->
      fdx_fn == (LINK_PASS && misc.full_duplex_enable))
    else $error("twisted pair duplex link state wrong");

  a_fdx_aui: assert property (
    @(posedge CLK) disable iff (RESET)
    ACTIVE_PORT == LSS_PORT_AUI |->
      fdx_fn == (misc.full_duplex_enable &&
                 misc.attach_port_fdx_enable))
    else $error("attach port duplex link state wrong");

  a_rx_filter: assert property (
    @(posedge CLK) disable iff (RESET)
    sel.rx_match_only && !RX_ADDR_MATCH |-> !func.rx)
    else $error("unmatched frame reached receive indication");

  a_fdx_keep: assert property (
    @(posedge CLK) disable iff (RESET)
    (SOFT_RESET_READ || STOP_CMD) && !do_write |=>
      $stable(misc))
    else $error("duplex bits changed without a write");

  a_write_resp: assert property (
    @(posedge CLK) disable iff (RESET)
    do_write |=> S_AXI_BVALID && !S_AXI_AWREADY)
    else $error("write response missing");

  a_reserved_kept: assert property (
    @(posedge CLK) disable iff (RESET)
    sel.res_hi == 5'h00 && !sel.res_mid && !sel.combined_function_state)
    else $error("reserved selection bits stored nonzero");

  a_fdx_serial: assert property (
    @(posedge CLK) disable iff (RESET)
    ACTIVE_PORT == LSS_PORT_SERIAL |-> fdx_fn == misc.full_duplex_enable)
    else $error("serial port duplex link state wrong");

  a_wake_shown: assert property (
    @(posedge CLK) disable iff (RESET)
    sel.wake_frame_ind_en && WAKE_FRAME_RX |-> comb)
    else $error("wake frame not shown in combined state");

  a_pin_dark: assert property (
    @(posedge CLK) disable iff (RESET)
    !comb && !busy |=> !THIRD_INDICATOR_PIN)
    else $error("indicator lit with nothing to show");

endmodule // lss_top

// ### pkg/lss_pkg.sv
// shared types and constants of the status indicator select block
package lss_pkg;

  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int LSS_ADDR_W = 8;
  localparam logic [7:0] LSS_OFS_SEL = 8'h00;
  localparam logic [7:0] LSS_OFS_MISC = 8'h04;
  localparam logic [1:0] LSS_RESP_OKAY = 2'h0;
  localparam logic [1:0] LSS_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic combined_function_state;
    logic [4:0] res_hi;
    logic wake_frame_ind_en;
    logic fdx_link_ind_en;
    logic stretch_enable;
    logic res_mid;
    logic rx_match_only;
    logic tx_activity_ind_en;
    logic rx_polarity_ind_en;
    logic rx_activity_ind_en;
    logic jabber_ind_en;
    logic collision_ind_en;
  } lss_sel_t;

  typedef struct packed {
    logic [13:0] res;
    logic attach_port_fdx_enable;
    logic full_duplex_enable;
  } lss_misc_t;

  localparam logic [15:0] LSS_SEL_RESET = 16'h0090;
  localparam logic [15:0] LSS_SEL_WMASK = 16'h03bf;
  localparam logic [15:0] LSS_MISC_RESET = 16'h0000;
  localparam logic [15:0] LSS_MISC_WMASK = 16'h0003;

  // ----------------------------------------------------------------
  // indicator functions, one bit each
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wake;
    logic fdx_link;
    logic tx;
    logic polarity;
    logic rx;
    logic jabber;
    logic collision;
  } lss_func_t;

  localparam int LSS_NFUNC = 7;

  typedef enum logic [1:0] {
    LSS_PORT_TP = 2'h0,
    LSS_PORT_AUI = 2'h1,
    LSS_PORT_SERIAL = 2'h3
  } lss_port_t;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int LSS_CLK_HZ = 50000000;
  localparam int LSS_STRETCH_TIME_MS = 50;
  localparam int LSS_STRETCH_CYCLES =
    (LSS_CLK_HZ / 1000) * LSS_STRETCH_TIME_MS;

  function automatic logic [15:0] lss_merge(
    input logic [15:0] old,
    input logic [15:0] data,
    input logic [3:0] strb,
    input logic [15:0] wmask);
    logic [15:0] m;
    m = wmask & {{8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (data & m);
  endfunction

endpackage

// ### core/lss_combine.sv
// OR of all enabled indicator functions
`timescale 1ns/10ps
module lss_combine
  import lss_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire lss_func_t func,
  input wire lss_func_t en,
  output logic comb
);

  logic [LSS_NFUNC-1:0] hit;

  genvar i;
  generate
    for (i = 0; i < LSS_NFUNC; i++) begin : g_fn
      assign hit[i] = func[i] & en[i];
    end
  endgenerate

  assign comb = |hit;

  a_or_combine: assert property (
    @(posedge clk) disable iff (reset)
    comb == ((func & en) != '0))
    else $error("combined state is not the OR of enabled functions");

endmodule // lss_combine

// ### core/lss_stretch.sv
// pulse stretcher: busy for a fixed count after each rising edge
`timescale 1ns/10ps
module lss_stretch
  import lss_pkg::*;
#(
  parameter int CYCLES = LSS_STRETCH_CYCLES,
  parameter int CNT_W = $clog2(CYCLES + 1)
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic comb,
  output logic busy
);

  logic prev;
  logic [CNT_W-1:0] cnt;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prev <= 1'b0;
    end else begin
      prev <= comb;
    end
  end

  // every new occurrence restarts the hold time
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt <= '0;
    end else if (comb && !prev) begin
      cnt <= CNT_W'(CYCLES);
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

  assign busy = (cnt != '0);

  a_hold_after_rise: assert property (
    @(posedge clk) disable iff (reset)
    (CYCLES >= 8) && comb && !prev |=> busy [*8])
    else $error("stretcher released too early");

endmodule // lss_stretch

// ### sim/lss_net_model.sv
// network event sources and indicator observer for the select block
`timescale 1ns/10ps
module lss_net_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] req,
  input wire logic pin,
  output logic [7:0] ev,
  output logic [15:0] lit_len
);
  logic was_lit;

  // ----------------------------------------------------------------
  // event sources
  // ----------------------------------------------------------------
  // levels change just after an edge, as the real sources do
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ev <= 8'h00;
    end else begin
      ev <= req;
    end
  end

  // ----------------------------------------------------------------
  // indicator observer
  // ----------------------------------------------------------------
  // length of the latest lit run, so the bench can judge the stretch
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      was_lit <= 1'b0;
      lit_len <= 16'h0000;
    end else begin
      was_lit <= pin;
      if (pin) begin
        lit_len <= (was_lit ? lit_len : 16'h0000) + 16'h0001;
      end
    end
  end
endmodule // lss_net_model

// ### sim/tb_lss_top.sv
// self-checking bench of the status indicator select block
`timescale 1ns/10ps
module tb_lss_top;
  import lss_pkg::*;
  localparam int S = 16;
  logic clk, reset, awv, wv, bready, arv, rready, srr, stop, pin;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, req, ev;
  logic [31:0] wdata, rdata, rdat;
  logic [1:0] bresp, rresp, resp;
  logic [3:0] strb;
  logic [15:0] lit_len, en;
  lss_port_t port;
  int errors, tests_run, i;
  // port code, duplex enables, link pass, expected pin
  logic [5:0] fdx_tab [8] = '{6'h04, 6'h07, 6'h02, 6'h16,
    6'h1d, 6'h35, 6'h32, 6'h2e};

  lss_top #(.STRETCH_CYCLES(S)) lss_top_i (
    .CLK(clk), .RESET(reset),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(strb),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .TX_ACTIVE(ev[4]), .RX_ACTIVE(ev[2]), .RX_ADDR_MATCH(ev[6]),
    .COLLISION(ev[0]), .JABBER(ev[1]), .RX_POLARITY_OK(ev[3]),
    .LINK_PASS(ev[7]), .WAKE_FRAME_RX(ev[5]), .ACTIVE_PORT(port),
    .SOFT_RESET_READ(srr), .STOP_CMD(stop), .THIRD_INDICATOR_PIN(pin)
  );

  lss_net_model lss_net_model_i (
    .clk(clk), .reset(reset), .req(req), .pin(pin),
    .ev(ev), .lit_len(lit_len)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic hang();
    errors++;
    $display("MISMATCH %0t bus wait timed out", $time);
    end_sim();
  endtask

  // address and data offered together; bready held until bvalid
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awv && awready) awv <= 1'b0;
      if (wv && wready) wv <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    resp = bresp;
    if (n == 50) hang();
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arv && arready) arv <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    rdat = rdata;
    resp = rresp;
    if (n == 50) hang();
  endtask

  task automatic set_ev(input logic [7:0] v);
    @(posedge clk);
    req <= v;
    repeat (3) @(posedge clk);
  endtask

  // one-cycle transmit burst, then time for any stretch to run out
  task automatic tx_pulse();
    @(posedge clk);
    req <= 8'h10;
    @(posedge clk);
    req <= 8'h00;
    repeat (S + 8) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_map();
    rd(LSS_OFS_SEL);
    check(rdat, 32'h0000_0090);
    rd(LSS_OFS_MISC);
    check(rdat, 32'h0000_0000);
    rd(8'h08);
    check({rdat[29:0], resp}, {30'h0, LSS_RESP_SLVERR});
    wr(8'h0c, 16'hffff);
    check({30'h0, resp}, {30'h0, LSS_RESP_SLVERR});
    // software keeps reserved bits zero; bit 15 is read-only
    wr(LSS_OFS_SEL, 16'h83bf);
    rd(LSS_OFS_SEL);
    check(rdat, 32'h0000_03bf);
    strb <= 4'h1;
    wr(LSS_OFS_SEL, 16'h0210);
    strb <= 4'hf;
    rd(LSS_OFS_SEL);
    check(rdat, 32'h0000_0310);
  endtask

  task automatic t_functions();
    for (i = 0; i < 6; i++) begin
      en = (i < 5) ? 16'h0001 << i : 16'h0200;
      wr(LSS_OFS_SEL, en);
      set_ev(8'h01 << i);
      check({31'h0, pin}, 32'h1);
      rd(LSS_OFS_SEL);
      check(rdat, {16'h0000, 16'h8000 | en});
      wr(LSS_OFS_SEL, 16'h021f & ~en);
      repeat (2) @(posedge clk);
      check({31'h0, pin}, 32'h0);
      set_ev(8'h01 << ((i + 1) % 6));
      check({31'h0, pin}, 32'h1);
      set_ev(8'h00);
    end
  endtask

  task automatic t_match();
    wr(LSS_OFS_SEL, 16'h0024);
    set_ev(8'h04);
    check({31'h0, pin}, 32'h0);
    set_ev(8'h44);
    check({31'h0, pin}, 32'h1);
    set_ev(8'h00);
  endtask

  task automatic t_duplex();
    wr(LSS_OFS_SEL, 16'h0100);
    for (i = 0; i < 8; i++) begin
      wr(LSS_OFS_MISC, {14'h0, fdx_tab[i][3:2]});
      port <= lss_port_t'(fdx_tab[i][5:4]);
      set_ev({fdx_tab[i][1], 7'h00});
      check({31'h0, pin}, {31'h0, fdx_tab[i][0]});
    end
    req <= 8'h00;
    port <= LSS_PORT_TP;
    srr <= 1'b1;
    stop <= 1'b1;
    @(posedge clk);
    srr <= 1'b0;
    stop <= 1'b0;
    rd(LSS_OFS_MISC);
    check(rdat, 32'h0000_0003);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(LSS_OFS_MISC);
    check(rdat, 32'h0000_0000);
  endtask

  task automatic t_stretch();
    tx_pulse();
    check({31'h0, lit_len inside {[S : S + 2]}}, 32'h1);
    wr(LSS_OFS_SEL, 16'h0010);
    tx_pulse();
    check({16'h0, lit_len}, 32'h0000_0001);
  endtask

  // ----------------------------------------------------------------
  // clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    errors = 0;
    tests_run = 0;
    {reset, awv, wv, bready, arv, rready, srr, stop} = 8'hff & 8'h80;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    strb = 4'hf;
    req = 8'h00;
    port = LSS_PORT_TP;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_reset_map();
    t_functions();
    t_match();
    t_duplex();
    t_stretch();
    end_sim();
  end
endmodule // tb_lss_top
